// *** rtl/mbs_consts.svh ***
// constants of the request responder
`ifndef MBS_CONSTS_SVH
`define MBS_CONSTS_SVH

`define MBS_FC_RD_COILS   8'h01
`define MBS_FC_RD_INPUTS  8'h02
`define MBS_FC_RD_HOLD    8'h03
`define MBS_FC_RD_INREG   8'h04
`define MBS_FC_WR_COIL    8'h05
`define MBS_FC_RD_EXCST   8'h06
`define MBS_EXC_FLAG      8'h80
`define MBS_EXC_NONE      8'h00
`define MBS_EXC_FUNC      8'h01
`define MBS_EXC_ADDR      8'h02
`define MBS_EXC_DATA      8'h03

`define MBS_ID_MIN        8'h01
`define MBS_ID_MAX        8'h7f
`define MBS_TCP_PORT      16'h01f6
`define MBS_TCP_PROTO     16'h0000
`define MBS_CRC_INIT      16'hffff
`define MBS_CRC_POLY      16'ha001

`define MBS_BUF_DEPTH     12
`define MBS_OFS_RTU       9'h001
`define MBS_OFS_TCP       9'h007
`define MBS_CRC_BYTES     9'h002
`define MBS_REQ_DATA      9'h004
`define MBS_MIN_RTU       8'h04
`define MBS_MIN_TCP       8'h08
`define MBS_LEN_HDR       8'h06
`define MBS_LEN_EXTRA     16'h0002

`define MBS_NCOIL_DEF     40
`define MBS_NREG_DEF      110
`define MBS_NCOIL_MAX     2000
`define MBS_NREG_MAX      125

`define MBS_CLK_HZ        250000000
`define MBS_CHAR_BITS     10
`define MBS_GAP_HALF_CHARS 7
`define MBS_BAUD_DEFAULT  3'h3
`define MBS_BAUD_0        1200
`define MBS_BAUD_1        2400
`define MBS_BAUD_2        4800
`define MBS_BAUD_3        9600
`define MBS_BAUD_4        19200
`define MBS_BAUD_5        38400
`define MBS_BAUD_6        57600
`define MBS_BAUD_7        115200

`endif

// *** rtl/mbs_pkg.sv ***
// types shared by the responder files
package mbs_pkg;
	typedef enum logic [3:0] {
		MBS_ST_RX   = 4'b0001,
		MBS_ST_EVAL = 4'b0010,
		MBS_ST_LOAD = 4'b0100,
		MBS_ST_SEND = 4'b1000
	} mbs_state_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       last;
	} mbs_byte_type;

	typedef struct packed {
		logic        tcp;
		logic [7:0]  fc;
		logic [7:0]  exc;
		logic [15:0] start;
		logic [15:0] qty;
		logic [15:0] tid;
		logic [7:0]  unit;
		logic [7:0]  pay;
		logic [8:0]  total;
	} mbs_req_type;
endpackage

// *** rtl/mbs_crc16.sv ***
// running crc-16 over a byte stream
`timescale 1ns/1ns
`include "mbs_consts.svh"
module mbs_crc16 (
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst,
	// byte stream
	input  wire logic        i_clear,
	input  wire logic        i_valid,
	input  wire logic [7:0]  i_data,
	// result
	output logic      [15:0] o_crc
);
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int b = 0; b < 8; b++)
			r = r[0] ? ((r >> 1) ^ `MBS_CRC_POLY) : (r >> 1);
		return r;
	endfunction

	// a clear together with a byte starts a new run with that byte
	wire [15:0] seed    = i_clear ? `MBS_CRC_INIT : o_crc;
	wire [15:0] crc_nxt = i_valid ? crc_step(seed, i_data) : seed;

	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			o_crc <= `MBS_CRC_INIT;
		else
			o_crc <= crc_nxt;
endmodule

// *** rtl/mbs_responder.sv ***
// request responder: frames, checks and answers read requests
`timescale 1ns/1ns
`include "mbs_consts.svh"
module mbs_responder #(
	parameter int NCOIL  = `MBS_NCOIL_DEF,
	parameter int NREG   = `MBS_NREG_DEF,
	parameter int CLK_HZ = `MBS_CLK_HZ
) (
	// clock and reset
	input  wire logic                 i_sys_clk,
	input  wire logic                 i_rst,
	// transport
	input  wire logic                 i_tcp_mode,
	input  wire logic [15:0]          i_tcp_port,
	input  wire mbs_pkg::mbs_byte_type i_rx,
	input  wire logic                 i_tx_ready,
	output mbs_pkg::mbs_byte_type     o_tx,
	// configuration
	input  wire logic [7:0]           i_slave_id,
	input  wire logic [2:0]           i_baud_sel,
	input  wire logic                 i_baud_load,
	output logic      [2:0]           o_baud_sel,
	// instrument data
	input  wire logic [NCOIL-1:0]     i_coil_state,
	input  wire logic [NREG*16-1:0]   i_meas_value,
	input  wire logic [7:0]           i_exc_status,
	// status
	output logic                      o_frame_drop
);
	if (NCOIL < 1 || NCOIL > `MBS_NCOIL_MAX || NREG < 2 || NREG > `MBS_NREG_MAX
		|| NREG % 2 != 0 || CLK_HZ < 1)
	begin : g_bad_param
		$error("mbs_responder: unsupported parameter values");
	end

	mbs_pkg::mbs_state_type state_r;
	mbs_pkg::mbs_state_type state_nxt;
	mbs_pkg::mbs_req_type   req_r;
	mbs_pkg::mbs_req_type   req_nxt;
	mbs_pkg::mbs_byte_type  tx_nxt;
	logic [7:0]             buf_r [`MBS_BUF_DEPTH];
	logic [7:0]             rx_cnt_r;
	logic [31:0]            gap_r;
	logic [8:0]             idx_r;
	logic [15:0]            rx_crc;
	logic [15:0]            tx_crc;
	logic [7:0]             crc_hi_r;

	// silence that ends a frame, rounded up to whole cycles
	function automatic logic [31:0] gap_cycles(input logic [2:0] sel);
		longint baud;
		longint num;
		case (sel)
			3'h0: baud = `MBS_BAUD_0;
			3'h1: baud = `MBS_BAUD_1;
			3'h2: baud = `MBS_BAUD_2;
			3'h3: baud = `MBS_BAUD_3;
			3'h4: baud = `MBS_BAUD_4;
			3'h5: baud = `MBS_BAUD_5;
			3'h6: baud = `MBS_BAUD_6;
			default: baud = `MBS_BAUD_7;
		endcase
		num = longint'(`MBS_GAP_HALF_CHARS) * `MBS_CHAR_BITS * CLK_HZ;
		return 32'((num + 2 * baud - 1) / (2 * baud));
	endfunction

	// byte k of a 32-bit field, most significant first
	function automatic logic [7:0] be_byte(input logic [31:0] w, input logic [1:0] k);
		logic [31:0] s;
		s = w >> {~k, 3'h0};
		return s[7:0];
	endfunction

	// read kinds of a function code, both used by request decode, the bit kind also by reply build
	function automatic logic fc_is_bit(input logic [7:0] fc);
		return fc == `MBS_FC_RD_COILS || fc == `MBS_FC_RD_INPUTS;
	endfunction

	function automatic logic fc_is_reg(input logic [7:0] fc);
		return fc == `MBS_FC_RD_HOLD || fc == `MBS_FC_RD_INREG;
	endfunction

	// byte k of the seven-byte tcp reply header
	function automatic logic [7:0] mbap_pick(input logic [2:0] k, input logic [15:0] tid,
		input logic [15:0] len, input logic [7:0] unit);
		logic [7:0] v;
		case (k)
			3'h0: v = tid[15:8];
			3'h1: v = tid[7:0];
			3'h2: v = 8'(`MBS_TCP_PROTO >> 8);
			3'h3: v = 8'(`MBS_TCP_PROTO);
			3'h4: v = len[15:8];
			3'h5: v = len[7:0];
			default: v = unit;
		endcase
		return v;
	endfunction

	wire st_rx   = state_r == mbs_pkg::MBS_ST_RX;
	wire st_eval = state_r == mbs_pkg::MBS_ST_EVAL;
	wire st_load = state_r == mbs_pkg::MBS_ST_LOAD;
	wire st_send = state_r == mbs_pkg::MBS_ST_SEND;

	// receive side; bytes arriving while answering are dropped, half-duplex
	wire        rx_take  = st_rx && i_rx.valid;
	wire        buf_we   = rx_take && rx_cnt_r < 8'(`MBS_BUF_DEPTH);
	wire [31:0] gap_lim  = gap_cycles(o_baud_sel);
	wire        end_rtu  = st_rx && !i_tcp_mode && rx_cnt_r != 8'h00
		&& !i_rx.valid && gap_r >= gap_lim;
	wire        end_tcp  = rx_take && i_tcp_mode && i_rx.last;
	wire [31:0] gap_nxt  = i_rx.valid ? 32'h0000_0000 :
		(gap_r < gap_lim ? gap_r + 32'h0000_0001 : gap_r);

	mbs_crc16 u_rx_crc (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_clear   (st_eval),
		.i_valid   (rx_take && !i_tcp_mode),
		.i_data    (i_rx.data),
		.o_crc     (rx_crc)
	);

	for (genvar g = 0; g < `MBS_BUF_DEPTH; g++)
	begin : g_buf
		always_ff @(posedge i_sys_clk or posedge i_rst)
			if (i_rst)
				buf_r[g] <= 8'h00;
			else if (buf_we && rx_cnt_r == 8'(g))
				buf_r[g] <= i_rx.data;
	end

	// request decode, evaluated the cycle after a frame ends
	// frames longer than the buffer still count, so the length checks see them
	wire [8:0]  ofs      = i_tcp_mode ? `MBS_OFS_TCP : `MBS_OFS_RTU;
	wire [8:0]  trail    = i_tcp_mode ? 9'h000 : `MBS_CRC_BYTES;
	wire [7:0]  rq_fc    = buf_r[4'(ofs)];
	wire [15:0] rq_start = {buf_r[4'(ofs + 9'h001)], buf_r[4'(ofs + 9'h002)]};
	wire [15:0] rq_qty   = {buf_r[4'(ofs + 9'h003)], buf_r[4'(ofs + 9'h004)]};
	wire [15:0] rq_proto = {buf_r[2], buf_r[3]};
	wire [15:0] rq_len   = {buf_r[4], buf_r[5]};
	wire        is_bit   = fc_is_bit(rq_fc);
	wire        is_reg   = fc_is_reg(rq_fc);
	wire        is_known = rq_fc >= `MBS_FC_RD_COILS && rq_fc <= `MBS_FC_RD_EXCST;
	wire        is_excst = rq_fc == `MBS_FC_RD_EXCST;
	wire [8:0]  need     = ofs + 9'h001 + (is_excst ? 9'h000 : `MBS_REQ_DATA) + trail;
	wire        full     = {1'b0, rx_cnt_r} >= need;
	wire [16:0] lim      = is_bit ? 17'(NCOIL) : 17'(NREG);
	wire [16:0] rng_end  = {1'b0, rq_start} + {1'b0, rq_qty};
	wire        is_read  = is_bit || is_reg;
	wire        bad_qty  = is_read && (rq_qty == 16'h0000 || {1'b0, rq_qty} > lim);
	wire        bad_rng  = is_read && rng_end > lim;
	wire [7:0]  exc_nxt  = !is_known ? `MBS_EXC_FUNC :
		(!full || bad_qty) ? `MBS_EXC_DATA :
		bad_rng ? `MBS_EXC_ADDR : `MBS_EXC_NONE;
	wire [16:0] bit_bytes = ({1'b0, rq_qty} + 17'h00007) >> 3;
	wire [7:0]  pay_nxt  = exc_nxt != `MBS_EXC_NONE ? 8'h01 :
		is_bit ? 8'(bit_bytes + 17'h00001) :
		is_reg ? 8'({rq_qty[6:0], 1'b0} + 8'h01) :
		rq_fc == `MBS_FC_WR_COIL ? 8'(`MBS_REQ_DATA) : 8'h01;
	// an out-of-range configured id silences the serial side altogether
	wire        id_ok    = i_slave_id >= `MBS_ID_MIN && i_slave_id <= `MBS_ID_MAX;
	wire        ok_rtu   = rx_cnt_r >= `MBS_MIN_RTU && rx_crc == 16'h0000
		&& id_ok && buf_r[0] == i_slave_id;
	wire        ok_tcp   = i_tcp_port == `MBS_TCP_PORT && rx_cnt_r >= `MBS_MIN_TCP
		&& rq_proto == `MBS_TCP_PROTO
		&& rq_len == 16'(rx_cnt_r - `MBS_LEN_HDR);
	// a refused frame leaves no trace but the drop pulse
	wire        accept   = i_tcp_mode ? ok_tcp : ok_rtu;

	always_comb
	begin
		req_nxt       = req_r;
		req_nxt.tcp   = i_tcp_mode;
		req_nxt.fc    = rq_fc;
		req_nxt.exc   = exc_nxt;
		req_nxt.start = rq_start;
		req_nxt.qty   = rq_qty;
		req_nxt.tid   = {buf_r[0], buf_r[1]};
		req_nxt.unit  = i_tcp_mode ? buf_r[6] : buf_r[0];
		req_nxt.pay   = pay_nxt;
		req_nxt.total = ofs + 9'h001 + {1'b0, pay_nxt} + trail;
	end

	// response byte selection
	// data are read live while answering, so a float may tear across its halves
	wire [8:0]  r_ofs    = req_r.tcp ? `MBS_OFS_TCP : `MBS_OFS_RTU;
	wire [8:0]  pd       = idx_r - r_ofs - 9'h001;
	wire [8:0]  dk       = pd - 9'h001;
	wire        r_exc    = req_r.exc != `MBS_EXC_NONE;
	wire        r_bit    = fc_is_bit(req_r.fc);
	wire [15:0] tcp_len  = {8'h00, req_r.pay} + `MBS_LEN_EXTRA;
	wire [16:0] coil_bit = {1'b0, req_r.start} + {5'h00, dk, 3'h0};
	wire [NCOIL+7:0] coil_sh = {8'h00, i_coil_state} >> coil_bit;
	wire [7:0]  coil_msk;
	wire [16:0] reg_idx  = {1'b0, req_r.start} + {9'h000, dk[8:1]};
	wire [NREG*16-1:0] reg_sh = i_meas_value >> {reg_idx, 4'h0};
	wire [7:0]  reg_byte = dk[0] ? reg_sh[7:0] : reg_sh[15:8];

	for (genvar b = 0; b < 8; b++)
	begin : g_msk
		assign coil_msk[b] = {5'h00, dk, 3'h0} + 17'(b) < {1'b0, req_r.qty};
	end

	wire [7:0]  coil_byte = coil_sh[7:0] & coil_msk;
	wire [7:0]  mbap_byte = mbap_pick(idx_r[2:0], req_r.tid, tcp_len, req_r.unit);
	wire [7:0]  data_byte = r_exc ? req_r.exc :
		req_r.fc == `MBS_FC_WR_COIL ? be_byte({req_r.start, req_r.qty}, pd[1:0]) :
		req_r.fc == `MBS_FC_RD_EXCST ? i_exc_status :
		pd == 9'h000 ? req_r.pay - 8'h01 :
		r_bit ? coil_byte : reg_byte;
	wire        at_crc_lo = !req_r.tcp && idx_r == req_r.total - 9'h002;
	wire        at_crc_hi = !req_r.tcp && idx_r == req_r.total - 9'h001;
	wire [7:0]  resp_byte = idx_r < r_ofs ? (req_r.tcp ? mbap_byte : req_r.unit) :
		idx_r == r_ofs ? (r_exc ? req_r.fc | `MBS_EXC_FLAG : req_r.fc) :
		at_crc_lo ? tx_crc[7:0] :
		at_crc_hi ? crc_hi_r : data_byte;
	wire        tx_hs     = st_send && i_tx_ready;

	mbs_crc16 u_tx_crc (
		.i_sys_clk (i_sys_clk),
		.i_rst     (i_rst),
		.i_clear   (st_eval),
		.i_valid   (tx_hs),
		.i_data    (o_tx.data),
		.o_crc     (tx_crc)
	);

	// the sent low check byte folds into the running crc, so its partner is kept aside
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			crc_hi_r <= 8'h00;
		else if (st_load && at_crc_lo)
			crc_hi_r <= tx_crc[15:8];

	// state sequencing; a byte waits a cycle so the crc sees its predecessor
	always_comb
	begin
		state_nxt = state_r;
		tx_nxt    = o_tx;
		case (state_r)
			mbs_pkg::MBS_ST_RX:
				if (end_rtu || end_tcp)
					state_nxt = mbs_pkg::MBS_ST_EVAL;
			mbs_pkg::MBS_ST_EVAL:
				state_nxt = accept ? mbs_pkg::MBS_ST_LOAD : mbs_pkg::MBS_ST_RX;
			mbs_pkg::MBS_ST_LOAD:
			begin
				tx_nxt.valid = 1'b1;
				tx_nxt.data  = resp_byte;
				tx_nxt.last  = idx_r == req_r.total - 9'h001;
				state_nxt    = mbs_pkg::MBS_ST_SEND;
			end
			mbs_pkg::MBS_ST_SEND:
				if (i_tx_ready)
				begin
					tx_nxt.valid = 1'b0;
					tx_nxt.last  = 1'b0;
					state_nxt    = o_tx.last ? mbs_pkg::MBS_ST_RX : mbs_pkg::MBS_ST_LOAD;
				end
			default:
				state_nxt = mbs_pkg::MBS_ST_RX;
		endcase
	end

	wire [7:0] rx_cnt_nxt = st_eval ? 8'h00 :
		(rx_take && rx_cnt_r != 8'hff) ? rx_cnt_r + 8'h01 : rx_cnt_r;
	wire [8:0] idx_nxt    = st_eval ? 9'h000 : tx_hs ? idx_r + 9'h001 : idx_r;

	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			state_r <= mbs_pkg::MBS_ST_RX;
			o_tx    <= '0;
			idx_r   <= 9'h000;
			rx_cnt_r <= 8'h00;
			gap_r   <= 32'h0000_0000;
		end
		else
		begin
			state_r <= state_nxt;
			o_tx    <= tx_nxt;
			idx_r   <= idx_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			gap_r   <= gap_nxt;
		end

	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
		begin
			req_r        <= '0;
			o_baud_sel   <= `MBS_BAUD_DEFAULT;
			o_frame_drop <= 1'b0;
		end
		else
		begin
			if (st_eval && accept)
				req_r <= req_nxt;
			if (i_baud_load)
				o_baud_sel <= i_baud_sel;
			o_frame_drop <= st_eval && !accept;
		end
endmodule

// *** dv/mbs_responder_props.sv ***
// port assertions for the request responder
`timescale 1ns/1ns
module mbs_responder_props (
	// clock and reset
	input wire logic                  i_sys_clk,
	input wire logic                  i_rst,
	// link
	input wire logic                  i_tcp_mode,
	input wire logic                  i_tx_ready,
	input wire mbs_pkg::mbs_byte_type o_tx,
	input wire logic                  o_frame_drop,
	// configuration
	input wire logic [7:0]            i_slave_id,
	input wire logic [2:0]            i_baud_sel,
	input wire logic                  i_baud_load,
	input wire logic [2:0]            o_baud_sel
);
	logic [7:0] idx_r;
	wire        hs = o_tx.valid && i_tx_ready;
	// byte position inside the reply, back to zero after the last handshake
	always_ff @(posedge i_sys_clk or posedge i_rst)
		if (i_rst)
			idx_r <= 8'h00;
		else if (hs)
			idx_r <= o_tx.last ? 8'h00 : idx_r + 8'h01;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	property p_baud_load;
		i_baud_load |=> o_baud_sel == $past(i_baud_sel);
	endproperty
	a_baud_load: assert property (p_baud_load) else $error("rate code not loaded");
	property p_baud_hold;
		!i_baud_load |=> $stable(o_baud_sel);
	endproperty
	a_baud_hold: assert property (p_baud_hold) else $error("rate code moved");
	property p_first_id;
		o_tx.valid && !i_tcp_mode && idx_r == 8'h00 |-> o_tx.data == i_slave_id;
	endproperty
	a_first_id: assert property (p_first_id) else $error("reply address wrong");
	property p_id_range;
		o_tx.valid && !i_tcp_mode && idx_r == 8'h00 |-> o_tx.data inside {[8'h01:8'h7f]};
	endproperty
	a_id_range: assert property (p_id_range) else $error("reply for bad address");
	property p_drop_quiet;
		o_frame_drop |-> !o_tx.valid ##1 (!o_tx.valid && !o_frame_drop);
	endproperty
	a_drop_quiet: assert property (p_drop_quiet) else $error("reply after drop");
	property p_tcp_proto;
		o_tx.valid && i_tcp_mode && idx_r inside {8'h02, 8'h03} |-> o_tx.data == 8'h00;
	endproperty
	a_tcp_proto: assert property (p_tcp_proto) else $error("protocol id not zero");
	property p_exc;
		hs && !i_tcp_mode && idx_r == 8'h01 && o_tx.data[7] |=>
			!o_tx.valid ##1 (o_tx.valid && o_tx.data inside {[8'h01:8'h03]});
	endproperty
	a_exc: assert property (p_exc) else $error("exception code bad");
	property p_cnt_even;
		hs && !i_tcp_mode && idx_r == 8'h01 && o_tx.data inside {8'h03, 8'h04} |=>
			!o_tx.valid ##1 (o_tx.valid && !o_tx.data[0]);
	endproperty
	a_cnt_even: assert property (p_cnt_even) else $error("odd register count");
endmodule

// *** dv/mbs_master_model.sv ***
// master model: sends requests byte by byte and collects replies
`timescale 1ns/1ns
module mbs_master_model (
	// clock and reset
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_rst,
	// control
	input  wire logic                  i_stall,
	// link
	input  wire mbs_pkg::mbs_byte_type i_tx,
	output mbs_pkg::mbs_byte_type      o_rx,
	output logic                       o_tx_ready
);
	logic [7:0] rsp[$];
	logic       done;
	initial
	begin
		o_rx = '0;
		o_tx_ready = 1'b0;
		done = 1'b0;
	end
	// toggling ready when stalled can delay only the first reply byte, by one cycle; later bytes arrive every second cycle and meet ready high
	always @(posedge i_sys_clk)
	begin
		o_tx_ready <= i_stall ? ~o_tx_ready : 1'b1;
		if (i_tx.valid && o_tx_ready)
		begin
			rsp.push_back(i_tx.data);
			if (i_tx.last)
				done <= 1'b1;
		end
	end
	task automatic send(input logic [7:0] f[$]);
		int i;
		rsp = {};
		done = 1'b0;
		for (i = 0; i < f.size(); i++)
		begin
			@(posedge i_sys_clk);
			o_rx <= '{1'b1, f[i], i == f.size() - 1};
			@(posedge i_sys_clk);
			o_rx <= '{1'b0, ~f[i], 1'b0};
		end
	endtask
endmodule

// *** dv/mbs_responder_tb.sv ***
// self-checking bench for the request responder
`timescale 1ns/1ns
module mbs_responder_tb;
	localparam int NC = 40;
	localparam int NR = 110;
	typedef logic [7:0] mbs_bq_type[$];
	logic                  i_sys_clk, i_rst, i_tcp_mode, i_baud_load, stall, tx_ready, drop;
	logic [15:0]           i_tcp_port, lfsr;
	logic [7:0]            i_slave_id, i_exc_status;
	logic [2:0]            i_baud_sel, baud;
	logic [NC-1:0]         i_coil_state;
	logic [NR*16-1:0]      i_meas_value;
	mbs_pkg::mbs_byte_type rx, tx;
	int                    mismatches, checks_done, drops, cyc, i;
	logic [7:0]            tf[10] = '{1, 2, 3, 4, 3, 3, 4, 5, 6, 8'h2b};
	logic [15:0]           ts[10] = '{2, 0, 9, NR - 1, 0, NR - 1, 0, 5, 0, 0};
	logic [15:0]           tq[10] = '{13, NC, 4, 1, 0, 2, NR + 1, 16'hff00, 0, 1};
	mbs_responder #(.NCOIL(NC), .NREG(NR), .CLK_HZ(1000000)) i_dut (
		.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tcp_mode(i_tcp_mode),
		.i_tcp_port(i_tcp_port), .i_rx(rx), .i_tx_ready(tx_ready), .o_tx(tx),
		.i_slave_id(i_slave_id), .i_baud_sel(i_baud_sel), .i_baud_load(i_baud_load),
		.o_baud_sel(baud), .i_coil_state(i_coil_state), .i_meas_value(i_meas_value),
		.i_exc_status(i_exc_status), .o_frame_drop(drop));
	mbs_master_model i_mst (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_stall(stall),
		.i_tx(tx), .o_rx(rx), .o_tx_ready(tx_ready));
	function automatic logic [15:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr;
	endfunction
	function automatic logic [15:0] crc(mbs_bq_type f);
		logic [15:0] c = 16'hffff;
		foreach (f[k])
		begin
			c ^= {8'h00, f[k]};
			repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
		end
		return c;
	endfunction
	function automatic mbs_bq_type pdu(logic [7:0] fc, logic [15:0] sa, q);
		mbs_bq_type p;
		int lim = fc < 8'h03 ? NC : NR;
		if (fc == 8'h00 || fc > 8'h06)
			return '{fc | 8'h80, 8'h01};
		if (fc == 8'h05)
			return '{fc, sa[15:8], sa[7:0], q[15:8], q[7:0]};
		if (fc == 8'h06)
			return '{fc, i_exc_status};
		if (q == 0 || q > lim)
			return '{fc | 8'h80, 8'h03};
		if (sa + q > lim)
			return '{fc | 8'h80, 8'h02};
		p = '{fc};
		p.push_back(fc < 8'h03 ? 8'((q + 7) / 8) : 8'(2 * q));
		for (int k = 0; k < q; k++)
			if (fc < 8'h03)
			begin
				if (k % 8 == 0)
					p.push_back(8'h00);
				p[p.size() - 1][k % 8] = i_coil_state[sa + k];
			end
			else
			begin
				p.push_back(i_meas_value[16 * (sa + k) + 8 +: 8]);
				p.push_back(i_meas_value[16 * (sa + k) +: 8]);
			end
		return p;
	endfunction
	task automatic check(logic [15:0] s, e);
		checks_done++;
		if (s !== e)
		begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic stop_test();
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one request, then either the full reply or a single drop pulse
	task automatic xact(logic [7:0] id, fc, logic [15:0] sa, q, logic ok, bad);
		mbs_bq_type f, e;
		logic [15:0] c, t;
		int d, n;
		t = rnd();
		e = pdu(fc, sa, q);
		f = '{fc, sa[15:8], sa[7:0], q[15:8], q[7:0]};
		if (i_tcp_mode)
		begin
			f = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'h06, t[11:4], f};
			e = {t[15:8], t[7:0], 8'h00, 8'h00, 8'h00, 8'(e.size() + 1), t[11:4], e};
		end
		else
		begin
			f.push_front(id);
			c = crc(f);
			f = {f, c[7:0] ^ {8{bad}}, c[15:8]};
			e.push_front(id);
			c = crc(e);
			e = {e, c[7:0], c[15:8]};
		end
		d = drops;
		i_mst.send(f);
		for (n = 0; n < 3000 && !i_mst.done && drops == d; n++)
			@(posedge i_sys_clk);
		check(i_mst.rsp.size(), ok ? e.size() : 0);
		check(drops - d, ok ? 0 : 1);
		foreach (e[k])
			if (ok && k < i_mst.rsp.size())
				check(i_mst.rsp[k], e[k]);
	endtask
	initial
	begin
		i_sys_clk = 1'b0;
		forever #2 i_sys_clk = ~i_sys_clk;
	end
	always @(posedge i_sys_clk)
	begin
		cyc++;
		if (drop)
			drops++;
		if (cyc == 40000)
		begin
			mismatches++;
			stop_test();
		end
	end
	initial
	begin
		lfsr = 16'hedba;
		i_rst = 1'b1;
		i_tcp_mode = 1'b0;
		i_tcp_port = 16'h01f6;
		i_slave_id = 8'(rnd() % 127 + 1);
		i_exc_status = 8'(rnd());
		i_baud_sel = 3'h0;
		i_baud_load = 1'b0;
		stall = 1'b1;
		i_coil_state = 40'({rnd(), rnd(), rnd()});
		for (i = 0; i < NR; i++)
			i_meas_value[16 * i +: 16] = rnd();
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		@(posedge i_sys_clk);
		check(baud, 3'h3);
		i_baud_sel <= 3'h7;
		i_baud_load <= 1'b1;
		@(posedge i_sys_clk);
		i_baud_load <= 1'b0;
		@(posedge i_sys_clk);
		check(baud, 3'h7);
		for (i = 0; i < 10; i++)
			xact(i_slave_id, tf[i], ts[i], tq[i], 1'b1, 1'b0);
		xact(i_slave_id + 8'h01, 8'h03, 16'h0000, 16'h0001, 1'b0, 1'b0);
		xact(i_slave_id, 8'h03, 16'h0000, 16'h0001, 1'b0, 1'b1);
		// a configured id outside the legal range must never answer a serial request
		i_slave_id <= 8'h80;
		@(posedge i_sys_clk);
		xact(8'h80, 8'h03, 16'h0000, 16'h0001, 1'b0, 1'b0);
		i_slave_id <= 8'h01;
		for (i = 0; i < 16; i++)
		begin
			stall <= lfsr[0];
			i_tcp_mode <= i > 7;
			@(posedge i_sys_clk);
			xact(8'h01, 8'(rnd() % 7 + 1), rnd() % 120, rnd() % 20, 1'b1, 1'b0);
		end
		i_tcp_port <= 16'h01f7;
		@(posedge i_sys_clk);
		xact(8'h01, 8'h03, 16'h0000, 16'h0001, 1'b0, 1'b0);
		stop_test();
	end
endmodule
bind mbs_responder mbs_responder_props i_props (
	.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_tcp_mode(i_tcp_mode), .i_tx_ready(i_tx_ready),
	.o_tx(o_tx), .o_frame_drop(o_frame_drop), .i_slave_id(i_slave_id),
	.i_baud_sel(i_baud_sel), .i_baud_load(i_baud_load), .o_baud_sel(o_baud_sel));
